// ### verilog/ntp_pkg.sv
// Package with register map, field layouts and reset values of the oscillator tuning registers.
package ntp_pkg;
    localparam int unsigned TW_W = 64;
    localparam int unsigned PH_W = 16;
    localparam int unsigned ACC_W = 32;
    localparam int unsigned ADDR_W = 12;
    // Printed offsets are not all multiples of four, so they are indices; byte address is four times.
    localparam logic [ADDR_W-1:0] IDX_OSC2_TW = 12'h330;
    localparam logic [ADDR_W-1:0] IDX_OSC3_TW = 12'h338;
    localparam logic [ADDR_W-1:0] IDX_OSC0_PH = 12'h340;
    localparam logic [ADDR_W-1:0] IDX_OSC1_PH = 12'h342;
    localparam logic [ADDR_W-1:0] IDX_CTRL = 12'h350;
    localparam logic [ADDR_W-1:0] IDX_STATUS = 12'h351;
    localparam logic [ADDR_W+1:0] ADR_OSC2_TW_LO = {IDX_OSC2_TW, 2'b00};
    localparam logic [ADDR_W+1:0] ADR_OSC2_TW_HI = {IDX_OSC2_TW, 2'b00} + 14'h0004;
    localparam logic [ADDR_W+1:0] ADR_OSC3_TW_LO = {IDX_OSC3_TW, 2'b00};
    localparam logic [ADDR_W+1:0] ADR_OSC3_TW_HI = {IDX_OSC3_TW, 2'b00} + 14'h0004;
    localparam logic [ADDR_W+1:0] ADR_OSC0_PH = {IDX_OSC0_PH, 2'b00};
    localparam logic [ADDR_W+1:0] ADR_OSC1_PH = {IDX_OSC1_PH, 2'b00};
    localparam logic [ADDR_W+1:0] ADR_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [ADDR_W+1:0] ADR_STATUS = {IDX_STATUS, 2'b00};
    // Control and status register fields and reset values.
    localparam int unsigned CTRL_SS_BIT = 0;
    localparam int unsigned CTRL_SRC_LSB = 1;
    localparam int unsigned SRC_W = 2;
    localparam int unsigned CTRL_DPEN_BIT = 3;
    localparam int unsigned CTRL_FREN_BIT = 4;
    localparam int unsigned CTRL_W = 5;
    localparam int unsigned STAT_PEND_BIT = 0;
    localparam int unsigned STAT_FREN_BIT = 1;
    localparam int unsigned STAT_W = 2;
    localparam logic [TW_W-1:0] TW_RST = 64'h0000_0000_0000_0000;
    localparam logic [PH_W-1:0] PH_RST = 16'h0000;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    localparam logic [ACC_W-1:0] ACC_RST = 32'h0000_0000;
    // Trigger sources selected by osc_update_trigger_select.
    localparam logic [SRC_W-1:0] SRC_SOFT = 2'h0;
    localparam logic [SRC_W-1:0] SRC_SYSREF = 2'h1;
    localparam logic [SRC_W-1:0] SRC_PIN = 2'h2;
    localparam logic [SRC_W-1:0] SRC_NONE = 2'h3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [1:0] ZERO2 = 2'h0;
endpackage

// ### verilog/ntp_osc.sv
// Phase accumulator with late phase offset for one oscillator.
module ntp_osc
    import ntp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic run_i,
    input wire logic [TW_W-1:0] tw_i,
    input wire logic [PH_W-1:0] ph_i,
    output logic [ACC_W-1:0] phase_o
);
    logic [TW_W-1:0] acc_reg;
    logic [ACC_W-1:0] phase_next;

    // Modulo-2^64 sum: signed and unsigned words give the same wrap.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            acc_reg <= TW_RST;
        end else if (run_i) begin
            acc_reg <= acc_reg + tw_i;
        end
    end

    // Offset is left justified and added after the accumulator.
    assign phase_next = acc_reg[TW_W-1 -: ACC_W] + {ph_i, {(ACC_W-PH_W){1'b0}}};

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_o <= ACC_RST;
        end else begin
            phase_o <= phase_next;
        end
    end
endmodule

// ### verilog/ntp_regs.sv
// Oscillator tuning and phase registers with shadow staging and AHB-Lite access.
// How it works
// - Oscillator advances by tuning word times 2^-64 of the sample rate.
// - Tuning word works identically read as signed or unsigned.
// - Written tuning words and phase offsets are staged and applied only at the selected sync event.
// - Fast reconfiguration mode overrides programmed tuning words and phase offsets.
// - Phase offset is left justified in 32 bits and added to accumulator.
// - Phase offset is a fraction of a full cycle, signed or unsigned.
// - Phase offset is applied after the accumulator, never resetting it.
//
// The AHB-Lite slave port was chosen for this implementation.
module ntp_regs
    import ntp_pkg::*;
(
    // Clock and reset.
    input wire logic CLK_SYS_I,
    input wire logic RSTN_I,
    // AHB-Lite slave.
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // Sync sources and fast reconfiguration settings.
    input wire logic SYSREF_EVENT_I,
    input wire logic PIN_EVENT_I,
    input wire logic [TW_W-1:0] FR_TW2_I,
    input wire logic [TW_W-1:0] FR_TW3_I,
    input wire logic [PH_W-1:0] FR_PH0_I,
    input wire logic [PH_W-1:0] FR_PH1_I,
    // Update event and oscillator phase outputs.
    output logic OSC_UPDATE_EVENT_O,
    output logic [ACC_W-1:0] OSC2_PHASE_O,
    output logic [ACC_W-1:0] OSC3_PHASE_O,
    output logic [ACC_W-1:0] OSC0_PHASE_OFFSET_O,
    output logic [ACC_W-1:0] OSC1_PHASE_OFFSET_O
);
    logic [TW_W-1:0] tw2_shadow_reg, tw3_shadow_reg, tw2_active_reg, tw3_active_reg;
    logic [PH_W-1:0] ph0_shadow_reg, ph1_shadow_reg, ph0_active_reg, ph1_active_reg;
    logic [CTRL_W-1:0] ctrl_reg;
    logic pending_reg;
    logic wr_pend_reg;
    logic [ADDR_W+1:0] wr_addr_reg;
    logic [31:0] rdata_next;
    logic addr_phase;
    logic sync_sel, fast_reconfig_enable, datapath_enable, trig, update;
    logic [SRC_W-1:0] src_sel;
    logic [TW_W-1:0] tw2_use, tw3_use;
    logic [PH_W-1:0] ph0_use, ph1_use;
    logic [ACC_W-1:0] osc2_phase, osc3_phase;

    assign sync_sel = ctrl_reg[CTRL_SS_BIT];
    assign src_sel = ctrl_reg[CTRL_SRC_LSB +: SRC_W];
    assign datapath_enable = ctrl_reg[CTRL_DPEN_BIT];
    assign fast_reconfig_enable = ctrl_reg[CTRL_FREN_BIT];
    assign addr_phase = HSEL_I && HREADY_I && HTRANS_I[1];

    // Zero-wait slave, always OKAY.
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else begin
            wr_pend_reg <= addr_phase && HWRITE_I;
            wr_addr_reg <= HADDR_I[ADDR_W+1:0];
        end
    end

    // Software writes land in shadows, except control writes, which go straight to ctrl_reg.
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            tw2_shadow_reg <= TW_RST;
            tw3_shadow_reg <= TW_RST;
            ph0_shadow_reg <= PH_RST;
            ph1_shadow_reg <= PH_RST;
            ctrl_reg <= CTRL_RST;
        end else if (wr_pend_reg) begin
            case (wr_addr_reg)
                ADR_OSC2_TW_LO: tw2_shadow_reg[31:0] <= HWDATA_I;
                ADR_OSC2_TW_HI: tw2_shadow_reg[63:32] <= HWDATA_I;
                ADR_OSC3_TW_LO: tw3_shadow_reg[31:0] <= HWDATA_I;
                ADR_OSC3_TW_HI: tw3_shadow_reg[63:32] <= HWDATA_I;
                ADR_OSC0_PH: ph0_shadow_reg <= HWDATA_I[PH_W-1:0];
                ADR_OSC1_PH: ph1_shadow_reg <= HWDATA_I[PH_W-1:0];
                ADR_CTRL: ctrl_reg <= HWDATA_I[CTRL_W-1:0];
                default: ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    // Selected trigger, honoured only while the sync select bit is set.
    always_comb begin
        case (src_sel)
            SRC_SOFT: trig = wr_pend_reg && (wr_addr_reg == ADR_CTRL) && HWDATA_I[CTRL_SS_BIT];
            SRC_SYSREF: trig = SYSREF_EVENT_I;
            SRC_PIN: trig = PIN_EVENT_I;
            default: trig = 1'b0;
        endcase
    end
    assign update = sync_sel && trig;

    // Pending flag: a new write sets it, the update clears it; set wins.
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            pending_reg <= 1'b0;
        end else if (wr_pend_reg && (wr_addr_reg inside {ADR_OSC2_TW_LO, ADR_OSC2_TW_HI, ADR_OSC3_TW_LO,
                     ADR_OSC3_TW_HI, ADR_OSC0_PH, ADR_OSC1_PH})) begin
            pending_reg <= 1'b1;
        end else if (update) begin
            pending_reg <= 1'b0;
        end
    end

    // All shadows move to active copies in one cycle.
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            tw2_active_reg <= TW_RST;
            tw3_active_reg <= TW_RST;
            ph0_active_reg <= PH_RST;
            ph1_active_reg <= PH_RST;
            OSC_UPDATE_EVENT_O <= 1'b0;
        end else begin
            OSC_UPDATE_EVENT_O <= update;
            if (update) begin
                tw2_active_reg <= tw2_shadow_reg;
                tw3_active_reg <= tw3_shadow_reg;
                ph0_active_reg <= ph0_shadow_reg;
                ph1_active_reg <= ph1_shadow_reg;
            end
        end
    end

    // Fast reconfiguration takes the settings from its own port.
    assign tw2_use = fast_reconfig_enable ? FR_TW2_I : tw2_active_reg;
    assign tw3_use = fast_reconfig_enable ? FR_TW3_I : tw3_active_reg;
    assign ph0_use = fast_reconfig_enable ? FR_PH0_I : ph0_active_reg;
    assign ph1_use = fast_reconfig_enable ? FR_PH1_I : ph1_active_reg;

    ntp_osc u_osc2 (
        .clk_i(CLK_SYS_I),
        .rstn_i(RSTN_I),
        .run_i(datapath_enable),
        .tw_i(tw2_use),
        .ph_i(PH_RST),
        .phase_o(osc2_phase)
    );

    ntp_osc u_osc3 (
        .clk_i(CLK_SYS_I),
        .rstn_i(RSTN_I),
        .run_i(datapath_enable),
        .tw_i(tw3_use),
        .ph_i(PH_RST),
        .phase_o(osc3_phase)
    );

    assign OSC2_PHASE_O = osc2_phase;
    assign OSC3_PHASE_O = osc3_phase;

    // Left-justified offsets for oscillators 0 and 1, whose accumulators live elsewhere.
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            OSC0_PHASE_OFFSET_O <= ACC_RST;
            OSC1_PHASE_OFFSET_O <= ACC_RST;
        end else begin
            OSC0_PHASE_OFFSET_O <= {ph0_use, {(ACC_W-PH_W){1'b0}}};
            OSC1_PHASE_OFFSET_O <= {ph1_use, {(ACC_W-PH_W){1'b0}}};
        end
    end

    // Read mux reads shadows; unmapped words read zero.
    always_comb begin
        case (HADDR_I[ADDR_W+1:0])
            ADR_OSC2_TW_LO: rdata_next = tw2_shadow_reg[31:0];
            ADR_OSC2_TW_HI: rdata_next = tw2_shadow_reg[63:32];
            ADR_OSC3_TW_LO: rdata_next = tw3_shadow_reg[31:0];
            ADR_OSC3_TW_HI: rdata_next = tw3_shadow_reg[63:32];
            ADR_OSC0_PH: rdata_next = {{(32-PH_W){1'b0}}, ph0_shadow_reg};
            ADR_OSC1_PH: rdata_next = {{(32-PH_W){1'b0}}, ph1_shadow_reg};
            ADR_CTRL: rdata_next = {{(32-CTRL_W){1'b0}}, ctrl_reg};
            ADR_STATUS: rdata_next = {{(32-STAT_W){1'b0}}, fast_reconfig_enable, pending_reg};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            HRDATA_O <= 32'h0000_0000;
        end else if (addr_phase && !HWRITE_I) begin
            HRDATA_O <= rdata_next;
        end
    end
endmodule

// ### sim/ntp_regs_props.sv
// Checker with concurrent properties on the ports of the tuning register block.
module ntp_regs_props
    import ntp_pkg::*;
(
    // Clock, reset and bus.
    input wire logic CLK_SYS_I,
    input wire logic RSTN_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O,
    // Sync sources, fast settings and outputs.
    input wire logic SYSREF_EVENT_I,
    input wire logic PIN_EVENT_I,
    input wire logic [PH_W-1:0] FR_PH0_I,
    input wire logic [PH_W-1:0] FR_PH1_I,
    input wire logic OSC_UPDATE_EVENT_O,
    input wire logic [ACC_W-1:0] OSC0_PHASE_OFFSET_O,
    input wire logic [ACC_W-1:0] OSC1_PHASE_OFFSET_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cause_reg;
    logic addr_ok;
    logic ctrl_wr;
    logic rd_unm;
    assign addr_ok = HSEL_I && HREADY_I && HTRANS_I[1];
    assign ctrl_wr = addr_ok && HWRITE_I && (HADDR_I[13:0] == ADR_CTRL);
    assign rd_unm = addr_ok && !HWRITE_I && !(HADDR_I[13:0] inside {ADR_OSC2_TW_LO, ADR_OSC2_TW_HI, ADR_OSC3_TW_LO,
        ADR_OSC3_TW_HI, ADR_OSC0_PH, ADR_OSC1_PH, ADR_CTRL, ADR_STATUS});
    // Remembers recent trigger candidates so an update pulse can be traced to one.
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cause_reg <= 5'h00;
        end else begin
            cause_reg <= {cause_reg[3:0], SYSREF_EVENT_I | PIN_EVENT_I | ctrl_wr};
        end
    end
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RSTN_I);
    a_off0_low_zero: assert property (OSC0_PHASE_OFFSET_O[15:0] == 16'h0000)
        else $error("offset 0 low half not zero");
    a_off1_low_zero: assert property (OSC1_PHASE_OFFSET_O[15:0] == 16'h0000)
        else $error("offset 1 low half not zero");
    a_off0_staged: assert property ($changed(OSC0_PHASE_OFFSET_O) |->
        $past(OSC_UPDATE_EVENT_O) || $past(OSC_UPDATE_EVENT_O, 2) || OSC0_PHASE_OFFSET_O[31:16] == FR_PH0_I)
        else $error("offset 0 changed without update");
    a_off1_staged: assert property ($changed(OSC1_PHASE_OFFSET_O) |->
        $past(OSC_UPDATE_EVENT_O) || $past(OSC_UPDATE_EVENT_O, 2) || OSC1_PHASE_OFFSET_O[31:16] == FR_PH1_I)
        else $error("offset 1 changed without update");
    a_event_has_cause: assert property (OSC_UPDATE_EVENT_O |-> |cause_reg)
        else $error("update pulse without trigger");
    a_event_one_cycle: assert property (OSC_UPDATE_EVENT_O |=> !OSC_UPDATE_EVENT_O)
        else $error("update pulse too long");
    a_bus_okay: assert property (HREADYOUT_O && !HRESP_O)
        else $error("bus not ready or error response");
    a_unmapped_zero: assert property (rd_unm |=> HRDATA_O == 32'h0000_0000)
        else $error("unmapped read not zero");
    c_update: cover property (OSC_UPDATE_EVENT_O);
    c_unmapped: cover property (rd_unm);
    c_off1_change: cover property ($changed(OSC1_PHASE_OFFSET_O));
endmodule

// ### sim/ntp_regs_tb.sv
// Self-checking bench for the oscillator tuning register block.
module ntp_regs_tb
    import ntp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, sys = 1'b0, pin = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, p2, p3;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic [15:0] fph0 = 16'h1234, fph1 = 16'h5678;
    logic [63:0] ftw = 64'h0000_0020_0000_0000;
    logic [13:0] map [6] = '{ADR_OSC2_TW_LO, ADR_OSC2_TW_HI, ADR_OSC3_TW_LO, ADR_OSC3_TW_HI, ADR_OSC0_PH, ADR_OSC1_PH};
    wire logic [31:0] hrdata, ph2, ph3, of0, of1;
    wire logic hready, hresp, ev;
    int bad_count = 0, n_tests = 0, cyc = 0;
    always #10 clk = ~clk;
    ntp_regs i_ntp_regs (.CLK_SYS_I(clk), .RSTN_I(rstn), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready), .HRESP_O(hresp), .SYSREF_EVENT_I(sys), .PIN_EVENT_I(pin), .FR_TW2_I(ftw),
        .FR_TW3_I(ftw), .FR_PH0_I(fph0), .FR_PH1_I(fph1), .OSC_UPDATE_EVENT_O(ev), .OSC2_PHASE_O(ph2),
        .OSC3_PHASE_O(ph3), .OSC0_PHASE_OFFSET_O(of0), .OSC1_PHASE_OFFSET_O(of1));
    task close_out();
        if (bad_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One single word transfer; read data is taken at the edge that ends the data phase.
    task ahb(input logic w, input logic [13:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        haddr <= {18'h0, a};
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task rdchk(input logic [13:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Measures the per-cycle advance of both accumulators.
    task step(input logic [31:0] e2, input logic [31:0] e3);
        tick(1);
        p2 = ph2;
        p3 = ph3;
        tick(1);
        chk(ph2 - p2, e2);
        chk(ph3 - p3, e3);
    endtask
    task pulse(input logic s, input logic p);
        @(posedge clk);
        sys <= s;
        pin <= p;
        @(posedge clk);
        sys <= 1'b0;
        pin <= 1'b0;
        tick(4);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 4000) begin
            bad_count++;
            close_out();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        foreach (map[i]) rdchk(map[i], 32'h0);
        ahb(1'b1, ADR_CTRL, 32'h00);
        ahb(1'b1, ADR_OSC2_TW_HI, 32'h10);
        ahb(1'b1, ADR_OSC3_TW_HI, 32'hFFFF_FFFF);
        ahb(1'b1, ADR_OSC0_PH, 32'h8001);
        ahb(1'b1, ADR_OSC1_PH, 32'h0003);
        rdchk(ADR_OSC3_TW_HI, 32'hFFFF_FFFF);
        rdchk(ADR_STATUS, 32'h1);
        ahb(1'b1, ADR_CTRL, 32'h09);
        tick(4);
        chk(of0, 32'h0);
        ahb(1'b1, ADR_CTRL, 32'h09);
        tick(4);
        chk(of0, 32'h8001_0000);
        chk(of1, 32'h0003_0000);
        rdchk(ADR_STATUS, 32'h0);
        step(32'h10, 32'hFFFF_FFFF);
        ahb(1'b1, ADR_CTRL, 32'h0A);
        ahb(1'b1, ADR_OSC0_PH, 32'h0001);
        rdchk(ADR_STATUS, 32'h1);
        ahb(1'b1, ADR_CTRL, 32'h0B);
        pulse(1'b0, 1'b1);
        chk(of0, 32'h8001_0000);
        p2 = ph2;
        pulse(1'b1, 1'b0);
        chk(of0, 32'h0001_0000);
        chk(ph2 - p2, 32'h60);
        ahb(1'b1, ADR_CTRL, 32'h0E);
        ahb(1'b1, ADR_OSC1_PH, 32'hABCD);
        ahb(1'b1, ADR_CTRL, 32'h0F);
        pulse(1'b1, 1'b1);
        chk(of1, 32'h0003_0000);
        ahb(1'b1, ADR_CTRL, 32'h0D);
        pulse(1'b0, 1'b1);
        chk(of1, 32'hABCD_0000);
        ahb(1'b1, ADR_CTRL, 32'h1D);
        tick(4);
        chk(of0, 32'h1234_0000);
        chk(of1, 32'h5678_0000);
        step(32'h20, 32'h20);
        rdchk(ADR_STATUS, 32'h2);
        ahb(1'b1, 14'h0100, 32'hFFFF_FFFF);
        rdchk(14'h0100, 32'h0);
        rdchk(ADR_STATUS, 32'h2);
        rdchk(ADR_OSC0_PH, 32'h0001);
        close_out();
    end
endmodule
bind ntp_regs ntp_regs_props i_ntp_regs_props (.CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .HSEL_I(HSEL_I),
    .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
    .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .SYSREF_EVENT_I(SYSREF_EVENT_I), .PIN_EVENT_I(PIN_EVENT_I),
    .FR_PH0_I(FR_PH0_I), .FR_PH1_I(FR_PH1_I), .OSC_UPDATE_EVENT_O(OSC_UPDATE_EVENT_O),
    .OSC0_PHASE_OFFSET_O(OSC0_PHASE_OFFSET_O), .OSC1_PHASE_OFFSET_O(OSC1_PHASE_OFFSET_O));
